// file: rtl/rce_exc_unit.sv
// Resource conflict exception unit with APB registers and drain control
`timescale 1ns/1ps
//
// Contract
// - Exceptions are raised only while the global exception enable bit of the task state is 1.
// - During an interrupt drain every packet not yet in the first execute phase is annulled.
// - Apparent conflicts from packets annulled during a drain raise no exception.
// - An exception seen during a drain is taken at handler arrival, saving state at that point.
// - Such a saved task state shows interrupt context 1, loop 0, blocked 0 and mode 00.
// - Such a saved return pointer masked with 0xffff_fe1f equals the masked vector table pointer.
// - A resource conflict sets the resource conflict bit of the cause register.
// - An internal exception sets the internal exception flag of the flag register.
// - Writing 2 to the clear register clears the internal exception flag.
// - Two live writes to one register in one cycle raise a valid conflict, drain or not.
module rce_exc_unit
  import rce_pkg::*;
#(
  parameter int NW = 4,
  parameter int RW = 6,
  parameter int NP = 6,
  parameter int PW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sequencing
  input wire logic int_start,
  input wire logic [ISR_NUM_W-1:0] int_num,
  input wire logic drain_done,
  input wire logic [DATA_W-1:0] exc_pc,
  // Register writes landing this cycle
  input wire logic [NW-1:0] wr_valid,
  input wire logic [NW-1:0] wr_annul,
  input wire logic [NW*RW-1:0] wr_reg,
  input wire logic [NW-1:0] wr_pred_en,
  input wire logic [NW-1:0] wr_pred_neg,
  input wire logic [NW*PW-1:0] wr_pred_idx,
  // Predicate register writes
  input wire logic pw_valid,
  input wire logic pw_annul,
  input wire logic [PW-1:0] pw_idx,
  input wire logic pw_val,
  // Pipeline and CPU outputs
  output logic annul_pre_e1,
  output logic [NP-1:0] committed_pred,
  output logic exc_take,
  output logic irq
);

  typedef struct packed {
    // Software-visible registers
    logic [DATA_W-1:0] task_state_reg;
    logic [DATA_W-1:0] vtp;
    logic [DATA_W-1:0] nmi_return_pointer;
    logic [DATA_W-1:0] nmi_saved_task_state;
    logic [DATA_W-1:0] cause;
    logic [DATA_W-1:0] exception_flag_reg;
    // Interrupt status and mask
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    // Pipeline tracking
    logic [NP-1:0] preds;
    logic [ISR_NUM_W-1:0] inum;
    logic draining;
    logic pend;
    logic take;
    // Registered outputs
    logic irq;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } rce_state_s;

  rce_state_s q;
  rce_state_s d;

  logic conflict;
  logic conflict_en;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic m;
    m = 1'b0;
    unique case (a)
      OFF_TASK_STATE: m = 1'b1;
      OFF_VECTOR_TABLE: m = 1'b1;
      OFF_NMI_RETURN: m = 1'b1;
      OFF_NMI_TASK_STATE: m = 1'b1;
      OFF_EXC_CAUSE: m = 1'b1;
      OFF_EXC_FLAG: m = 1'b1;
      OFF_EXC_CLEAR: m = 1'b1;
      OFF_IRQ_STATUS: m = 1'b1;
      OFF_IRQ_MASK: m = 1'b1;
      default: m = 1'b0;
    endcase
    addr_mapped = m;
  endfunction : addr_mapped

  function automatic logic [DATA_W-1:0] read_mux(input rce_state_s s,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] r;
    r = '0;
    unique case (a)
      OFF_TASK_STATE: r = s.task_state_reg;
      OFF_VECTOR_TABLE: r = s.vtp;
      OFF_NMI_RETURN: r = s.nmi_return_pointer;
      OFF_NMI_TASK_STATE: r = s.nmi_saved_task_state;
      OFF_EXC_CAUSE: r = s.cause;
      OFF_EXC_FLAG: r = s.exception_flag_reg;
      OFF_IRQ_STATUS: r = DATA_W'(s.ist);
      OFF_IRQ_MASK: r = DATA_W'(s.imask);
      default: r = '0;
    endcase
    read_mux = r;
  endfunction : read_mux

  // Byte-lane merge of a write into a register
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [3:0] st);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Annulled writes never reach the conflict check
  rce_conflict_chk #(
    .NW(NW),
    .RW(RW),
    .NP(NP),
    .PW(PW)
  ) i_rce_conflict_chk (
    .wr_valid(wr_valid),
    .wr_annul(wr_annul),
    .wr_reg(wr_reg),
    .wr_pred_en(wr_pred_en),
    .wr_pred_neg(wr_pred_neg),
    .wr_pred_idx(wr_pred_idx),
    .pred_vals(q.preds),
    .conflict(conflict)
  );

  // Predicates come from q, so a same-cycle predicate write never feeds the check
  // Exceptions gated by the global enable
  assign conflict_en = conflict && q.task_state_reg[TSR_GLOBAL_EXC_EN_BIT];

  always_comb begin
    logic access;
    logic wr_fire;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] efr_clr;
    logic [DATA_W-1:0] cause_clr;
    logic [IRQ_W-1:0] ist_clr;
    logic [IRQ_W-1:0] ist_set;
    logic take_now;
    logic take_drain;
    logic [DATA_W-1:0] nmi_saved_task_state_drain;
    access = 1'b0;
    wr_fire = 1'b0;
    wd = '0;
    efr_clr = '0;
    cause_clr = '0;
    ist_clr = '0;
    ist_set = '0;
    take_now = 1'b0;
    take_drain = 1'b0;
    nmi_saved_task_state_drain = '0;
    d = q;

    // APB: one wait state, pready from a flop
    access = psel && penable;
    wd = merge('0, pwdata, pstrb);
    if (access && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !addr_mapped(paddr);
      d.prdata = pwrite ? '0 : read_mux(q, paddr);
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.prdata = '0;
    end
    // Commit only at the edge where pready is sampled high
    wr_fire = access && q.pready && pwrite && !q.pslverr;

    if (wr_fire) begin
      unique case (paddr)
        OFF_TASK_STATE: d.task_state_reg = merge(q.task_state_reg, pwdata, pstrb);
        OFF_VECTOR_TABLE: d.vtp = merge(q.vtp, pwdata, pstrb);
        OFF_EXC_CAUSE: cause_clr = wd;
        OFF_EXC_CLEAR: efr_clr = wd;
        OFF_IRQ_STATUS: ist_clr = wd[IRQ_W-1:0];
        OFF_IRQ_MASK: d.imask = wd[IRQ_W-1:0];
        default: d.prdata = d.prdata;
      endcase
    end

    // Committed predicate file ignores annulled packets
    if (pw_valid && !pw_annul && (pw_idx < PW'(NP))) begin
      d.preds[pw_idx] = pw_val;
    end

    // Drain sequencing
    if (q.draining) begin
      if (drain_done) begin
        d.draining = 1'b0;
        d.pend = 1'b0;
        take_drain = q.pend || conflict_en;
      end else if (conflict_en) begin
        d.pend = 1'b1; // Deferred until handler arrival
      end
    end else if (int_start) begin
      d.draining = 1'b1;
      d.pend = conflict_en;
      d.inum = int_num;
    end else begin
      take_now = conflict_en;
    end

    // Saved state at handler arrival
    nmi_saved_task_state_drain = q.task_state_reg;
    nmi_saved_task_state_drain[TSR_INT_CTX_BIT] = 1'b1;
    nmi_saved_task_state_drain[TSR_LOOP_ACTIVE_BIT] = 1'b0;
    nmi_saved_task_state_drain[TSR_INT_BLOCKED_BIT] = 1'b0;
    nmi_saved_task_state_drain[TSR_EXEC_MODE_LSB +: TSR_EXEC_MODE_W] = EXEC_MODE_SUPERVISOR;

    if (take_drain) begin
      // Service fetch packet address
      d.nmi_return_pointer = (q.vtp & ISR_FETCH_MASK) | (DATA_W'(q.inum) << ISR_NUM_LSB);
      d.nmi_saved_task_state = nmi_saved_task_state_drain;
      ist_set[IRQ_DRAIN_EXC_BIT] = 1'b1;
    end else if (take_now) begin
      d.nmi_return_pointer = exc_pc;
      d.nmi_saved_task_state = q.task_state_reg;
    end

    // Sticky flags: set wins over a same-cycle clear
    d.take = take_drain || take_now;
    if (d.take) begin
      ist_set[IRQ_EXC_TAKEN_BIT] = 1'b1;
    end
    d.exception_flag_reg = q.exception_flag_reg & ~efr_clr;
    d.cause = q.cause & ~cause_clr;
    if (d.take) begin
      d.exception_flag_reg[EFR_INTERNAL_EXC_BIT] = 1'b1;
      d.cause[CAUSE_RES_CONFLICT_BIT] = 1'b1;
    end
    d.ist = (q.ist & ~ist_clr) | ist_set;
    // From d so irq rises with the status bit, not a cycle later
    d.irq = |(d.ist & d.imask);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q.task_state_reg <= TASK_STATE_RST;
      q.vtp <= VECTOR_TABLE_RST;
      q.nmi_return_pointer <= NMI_RETURN_RST;
      q.nmi_saved_task_state <= NMI_TASK_STATE_RST;
      q.cause <= EXC_CAUSE_RST;
      q.exception_flag_reg <= EXC_FLAG_RST;
      q.ist <= IRQ_RST;
      q.imask <= IRQ_RST;
      q.preds <= '0;
      q.inum <= '0;
      q.draining <= 1'b0;
      q.pend <= 1'b0;
      q.take <= 1'b0;
      q.irq <= 1'b0;
      q.prdata <= '0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign annul_pre_e1 = q.draining;
  assign committed_pred = q.preds;
  assign exc_take = q.take;
  assign irq = q.irq;

endmodule : rce_exc_unit

// file: rtl/rce_pkg.sv
// Package: constants of the resource conflict exception unit
package rce_pkg;

  // APB geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TASK_STATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_VECTOR_TABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_NMI_RETURN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_NMI_TASK_STATE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EXC_CAUSE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EXC_FLAG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EXC_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;

  // Task state fields
  localparam int TSR_GLOBAL_EXC_EN_BIT = 2;
  localparam int TSR_LOOP_ACTIVE_BIT = 9;
  localparam int TSR_INT_BLOCKED_BIT = 10;
  localparam int TSR_INT_CTX_BIT = 15;
  localparam int TSR_EXEC_MODE_LSB = 16;
  localparam int TSR_EXEC_MODE_W = 2;
  localparam logic [TSR_EXEC_MODE_W-1:0] EXEC_MODE_SUPERVISOR = 2'h0;

  // Exception flag and cause fields
  localparam int EFR_INTERNAL_EXC_BIT = 1;
  localparam int CAUSE_RES_CONFLICT_BIT = 6;

  // Interrupt service fetch packet address
  localparam logic [DATA_W-1:0] ISR_FETCH_MASK = 32'hffff_fe1f;
  localparam int ISR_NUM_LSB = 5;
  localparam int ISR_NUM_W = 4;

  // Interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_EXC_TAKEN_BIT = 0;
  localparam int IRQ_DRAIN_EXC_BIT = 1;

  // Reset values
  localparam logic [DATA_W-1:0] TASK_STATE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] VECTOR_TABLE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] NMI_RETURN_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] NMI_TASK_STATE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EXC_CAUSE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] EXC_FLAG_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

endpackage : rce_pkg

// file: rtl/rce_conflict_chk.sv
// Combinational same-cycle register write conflict detector
`timescale 1ns/1ps
module rce_conflict_chk
  import rce_pkg::*;
#(
  parameter int NW = 4,
  parameter int RW = 6,
  parameter int NP = 6,
  parameter int PW = 3
) (
  // Writes landing this cycle
  input wire logic [NW-1:0] wr_valid,
  input wire logic [NW-1:0] wr_annul,
  input wire logic [NW*RW-1:0] wr_reg,
  // Predicate of each write
  input wire logic [NW-1:0] wr_pred_en,
  input wire logic [NW-1:0] wr_pred_neg,
  input wire logic [NW*PW-1:0] wr_pred_idx,
  // Committed predicate values
  input wire logic [NP-1:0] pred_vals,
  // Result
  output logic conflict
);

  function automatic logic pred_pass(input logic en, input logic neg,
                                     input logic [PW-1:0] idx,
                                     input logic [NP-1:0] vals);
    logic v;
    v = (idx < PW'(NP)) ? vals[idx] : 1'b0;
    pred_pass = !en || (v ^ neg);
  endfunction : pred_pass

  logic [NW-1:0] eff;
  logic [NW*NW-1:0] hit;

  genvar i, j;
  generate
    for (i = 0; i < NW; i++) begin : g_eff
      // Annulled packets and committed-only predicates
      assign eff[i] = wr_valid[i] && !wr_annul[i] &&
                      pred_pass(wr_pred_en[i], wr_pred_neg[i],
                                wr_pred_idx[i*PW +: PW], pred_vals);
      for (j = 0; j < NW; j++) begin : g_pair
        if (j > i) begin : g_cmp
          // Two live writes to one register in one cycle
          assign hit[i*NW+j] = eff[i] && eff[j] &&
                               (wr_reg[i*RW +: RW] == wr_reg[j*RW +: RW]);
        end else begin : g_none
          assign hit[i*NW+j] = 1'b0;
        end
      end
    end
  endgenerate

  assign conflict = |hit;

endmodule : rce_conflict_chk

// file: tb/rce_exc_unit_sva.sv
// Port timing checker of the exception unit
`timescale 1ns/1ps
module rce_exc_unit_sva
  import rce_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drain and exception
  input wire logic int_start,
  input wire logic drain_done,
  input wire logic annul_pre_e1,
  input wire logic exc_take
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("prdata not idle");
  drain_rise_a: assert property (int_start && !annul_pre_e1 |=> annul_pre_e1)
    else $error("annul late");
  drain_hold_a: assert property (annul_pre_e1 && !drain_done |=> annul_pre_e1)
    else $error("annul dropped");
  drain_fall_a: assert property (annul_pre_e1 && drain_done |=> !annul_pre_e1)
    else $error("annul stuck");
  annul_idle_a: assert property (!annul_pre_e1 && !int_start |=> !annul_pre_e1)
    else $error("annul without drain");
  take_gate_a: assert property (exc_take |-> !annul_pre_e1)
    else $error("exception inside drain");
endmodule : rce_exc_unit_sva
bind rce_exc_unit rce_exc_unit_sva i_rce_exc_unit_sva (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .int_start(int_start), .drain_done(drain_done), .annul_pre_e1(annul_pre_e1),
  .exc_take(exc_take));

// file: tb/rce_pipe_model.sv
// Pipeline and interrupt sequencing model
`timescale 1ns/1ps
module rce_pipe_model
  import rce_pkg::*;
#(
  parameter int NW = 4,
  parameter logic [7:0] LEN = 8'h04
) (
  // Clock, reset and command
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [ISR_NUM_W-1:0] num,
  // Packets before the first execute phase
  input wire logic annul_pre_e1,
  input wire logic [NW-1:0] young,
  input wire logic pw_young,
  // Sequencing
  output logic int_start,
  output logic [ISR_NUM_W-1:0] int_num,
  output logic drain_done,
  // Annul marks
  output logic [NW-1:0] wr_annul,
  output logic pw_annul
);
  logic busy_q;
  logic [7:0] cnt_q;
  // Young packets die while the drain is open
  assign wr_annul = annul_pre_e1 ? young : '0;
  assign pw_annul = annul_pre_e1 & pw_young;
  always_ff @(posedge clock) begin
    int_start <= 1'b0;
    drain_done <= 1'b0;
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      int_num <= '0;
    end else if (go && !busy_q) begin
      int_start <= 1'b1;
      int_num <= num;
      busy_q <= 1'b1;
      cnt_q <= LEN;
    end else if (busy_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (busy_q) begin
      drain_done <= 1'b1;
      busy_q <= 1'b0;
    end
  end
endmodule : rce_pipe_model

// file: tb/tb.sv
// Self-checking bench of the exception unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb import rce_pkg::*; ;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, exc_pc = '0, rdata, prdata;
  logic [3:0] wr_valid = '0, wr_pred_en = '0, wr_pred_neg = '0, young = '0, pstrb = 4'hf;
  logic [23:0] wr_reg = {4{6'h05}};
  logic pw_valid = 1'b0, pw_young = 1'b0, go = 1'b0;
  logic pready, pslverr, int_start, drain_done, annul_pre_e1, exc_take, irq, perr, pw_annul;
  logic [3:0] int_num, wr_annul;
  logic [5:0] committed_pred;
  int mismatches = 0, n_compared = 0, n_take = 0;
  always #4 clock = ~clock;
  always @(posedge clock) if (exc_take === 1'b1) n_take++;
  rce_exc_unit i_rce_exc_unit (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .int_start, .int_num, .drain_done, .exc_pc,
    .wr_valid, .wr_annul, .wr_reg, .wr_pred_en, .wr_pred_neg,
    .wr_pred_idx(12'h000), .pw_valid, .pw_annul, .pw_idx(3'h0), .pw_val(1'b1),
    .annul_pre_e1, .committed_pred, .exc_take, .irq);
  rce_pipe_model i_rce_pipe_model (.clock, .rst_n, .go, .num(4'h3), .annul_pre_e1, .young,
    .pw_young, .int_start, .int_num(int_num), .drain_done, .wr_annul, .pw_annul);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata; perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    `CHK(s, e, rdata)
  endtask : rd
  task automatic pipe(input logic [3:0] v, yg, pe, ng, input logic [1:0] p);
    wr_valid <= v; young <= yg; wr_pred_en <= pe; wr_pred_neg <= ng;
    pw_valid <= p[1]; pw_young <= p[0];
    @(posedge clock);
    wr_valid <= '0; pw_valid <= 1'b0;
    repeat (9) @(posedge clock);
  endtask : pipe
  task automatic drain(input logic [3:0] v, yg, pe, input logic [1:0] p);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("annul", 1'b1, annul_pre_e1)
    pipe(v, yg, pe, 4'h0, p);
    `CHK("annul", 1'b0, annul_pre_e1)
  endtask : drain
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #40000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd("tsr", OFF_TASK_STATE, TASK_STATE_RST);
    rd("cause", OFF_EXC_CAUSE, EXC_CAUSE_RST);
    `CHK("slverr", 1'b0, perr)
    rd("hole", 8'h40, 32'h0);
    `CHK("slverr", 1'b1, perr)
    pipe(4'b0011, 4'h0, 4'h0, 4'h0, 2'b00);
    `CHK("take", 0, n_take)
    rd("flag", OFF_EXC_FLAG, 32'h0);
    $display("test reset and disabled done");
    apb(1'b1, OFF_TASK_STATE, 32'h0001_0604);
    apb(1'b1, OFF_IRQ_MASK, 32'h3);
    exc_pc <= 32'h0000_1234;
    pipe(4'b0011, 4'h0, 4'b0011, 4'b0011, 2'b00);
    `CHK("take", 1, n_take)
    rd("flag", OFF_EXC_FLAG, 32'h2);
    rd("cause", OFF_EXC_CAUSE, 32'h40);
    rd("ret", OFF_NMI_RETURN, 32'h0000_1234);
    rd("nmi_saved_task_state", OFF_NMI_TASK_STATE, 32'h0001_0604);
    rd("status", OFF_IRQ_STATUS, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFF_EXC_CLEAR, 32'h2);
    apb(1'b1, OFF_EXC_CAUSE, 32'h40);
    apb(1'b1, OFF_IRQ_STATUS, 32'h3);
    rd("flag", OFF_EXC_FLAG, 32'h0);
    rd("clear", OFF_EXC_CLEAR, 32'h0);
    `CHK("irq", 1'b0, irq)
    wr_reg <= {6'h05, 6'h05, 6'h06, 6'h05};
    pipe(4'b0011, 4'h0, 4'h0, 4'h0, 2'b00);
    `CHK("take", 1, n_take)
    wr_reg <= {4{6'h05}};
    $display("test live conflict done");
    apb(1'b1, OFF_VECTOR_TABLE, 32'h8000_0400);
    drain(4'b1111, 4'b0011, 4'b1100, 2'b11);
    `CHK("take", 1, n_take)
    `CHK("pred", 6'h00, committed_pred)
    drain(4'b0011, 4'h0, 4'h0, 2'b10);
    `CHK("take", 2, n_take)
    `CHK("pred", 6'h01, committed_pred)
    rd("ret", OFF_NMI_RETURN, 32'h8000_0460);
    rd("nmi_saved_task_state", OFF_NMI_TASK_STATE, 32'h0000_8004);
    rd("cause", OFF_EXC_CAUSE, 32'h40);
    rd("flag", OFF_EXC_FLAG, 32'h2);
    rd("status", OFF_IRQ_STATUS, 32'h3);
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    rd("mask", OFF_IRQ_MASK, 32'h0);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, OFF_TASK_STATE, 32'h0);
    drain(4'b0011, 4'h0, 4'h0, 2'b00);
    `CHK("take", 2, n_take)
    pstrb <= 4'h1;
    apb(1'b1, OFF_VECTOR_TABLE, 32'hffff_ffaa);
    pstrb <= 4'hf;
    rd("vtp", OFF_VECTOR_TABLE, 32'h8000_04aa);
    $display("test drain done");
    conclude();
  end
endmodule : tb
